/* src/carriage_skip_interlock_consts.vh */
/*
  Constants for the carriage skip and interlock control block: register
  offsets, field positions, reset values and carriage figures.
  Assumes inclusion by its bare name from the design file.
*/
`ifndef CARRIAGE_SKIP_INTERLOCK_CONSTS_VH
`define CARRIAGE_SKIP_INTERLOCK_CONSTS_VH

// Register byte offsets on the APB.
`define OFS_CTRL 12'h000
`define OFS_EXIT_LO 12'h004
`define OFS_EXIT_HI 12'h008
`define OFS_STATUS 12'h00c
`define OFS_ORDERS 12'h010

// Control register fields.
`define CTRL_SUPPRESS 0
`define CTRL_FCM_WIRED 1
`define CTRL_OF_TO_ONE 2
`define CTRL_RESET 32'h0000_0002

// Exit map reset value: every release input unwired.
`define EXIT_RESET 32'h0000_0000

// Status register fields.
`define ST_HEAD_LATCH 0
`define ST_FIRST_HEAD 1
`define ST_HEAD_CARD 2
`define ST_BODY_START 3
`define ST_SKIP_RUN 4
`define ST_SKIP_START 5
`define ST_PAST_ONE 6
`define ST_REL_RELAY 7
`define ST_HS_STOP 8
`define ST_CLUTCH 9
`define ST_OVERFLOW 10
`define ST_HEAD_AUX 11
`define ST_IN_FLIGHT 12
`define ST_LINES_LSB 16

// Orders register fields.
`define ORD_LSB 0
`define LAT_LSB 16

// Carriage figures.
`define SKIP_START_DEG 265
`define LINES_PER_PRINT_CYCLE 6'd22

`endif

/* src/carriage_skip_interlock_control.v */
/*
  Skip sequencing and print/carriage interlock for a tape-controlled form
  carriage, with heading-card control and an APB register slave.
  Assumes machine timing (cams, carriage breaker) and tape brushes arrive
  as pins from outside the pclk domain; they are synchronised here.
*/
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
// Notes on behaviour
// RULE1: heading mark sets heading latch and relays
// RULE2: first heading without body start blocks skip-two
// RULE3: heading card relay suspends total programming
// RULE4: first-card minor impulse sets skip-to-one order
// RULE5: any order energizes skip run, then start
// RULE6: no heading cards: pass one, stop two
// RULE7: both relays off, skip-one set: set two
// RULE8: channel one hole in combined skip sets past-one
// RULE9: armed channel hole at breaker stops carriage
// RULE10: skip-one set on earlier cam than pulse
// RULE11: clutch latched during skip without release wiring
// RULE12: skip starts at cam; 22 lines per cycle
// RULE13: suppression bypasses interlock on normal skips
// RULE14: overflow always latches clutch, even suppressed; code lets the release relay free it, blocking its pick only with of_to_one
// RULE15: suppressed long skip flags printing in flight
// RULE16: wired tape exit releases one short skip
// RULE17: release latch set by hole, tripped at own brush
// RULE18: release inputs may share one tape exit
// RULE19: release relay at cam bypasses interlock point
// RULE20: release only through highest pending order
// RULE21: orders and past-one held until stop
`include "carriage_skip_interlock_consts.vh"
`default_nettype none

module carriage_skip_interlock_control (
  // Clock, reset and enable.
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Card reading and programming pins.
  input wire heading_mark,
  input wire card_read,
  input wire group_change,
  input wire first_card_minor,
  input wire overflow_output,
  input wire [10:0] skip_request,
  // Machine timing pins.
  input wire early_first_card_cam,
  input wire early_all_cycle_impulse,
  input wire skip_two_program_pulse,
  input wire skip_start_cam,
  input wire release_pick_cam,
  input wire carriage_breaker,
  // Carriage tape brushes, channel 1 in bit 0.
  input wire [11:0] tape_brush,
  // Relay drives.
  output reg skip_run_relay,
  output reg carriage_skip_start,
  output reg high_speed_stop_relay,
  output reg card_feed_clutch_control,
  output reg interlock_release_relay,
  output reg total_program_start,
  output reg heading_card_relay
);

  localparam NIN = 34;

  // Two-flop synchronisers and a third stage for edge detection.
  wire [NIN-1:0] raw_in;
  reg [NIN-1:0] sync1_ff;
  reg [NIN-1:0] sync2_ff;
  reg [NIN-1:0] sync3_ff;
  wire [NIN-1:0] rise;
  assign raw_in = {heading_mark, card_read, group_change, first_card_minor,
                   overflow_output, skip_request, early_first_card_cam,
                   early_all_cycle_impulse, skip_two_program_pulse,
                   skip_start_cam, release_pick_cam, carriage_breaker,
                   tape_brush};
  assign rise = sync2_ff & ~sync3_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= {NIN{1'b0}};
      sync2_ff <= {NIN{1'b0}};
      sync3_ff <= {NIN{1'b0}};
    end else if (ce) begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  wire [11:0] brush = sync2_ff[11:0];
  wire brk_p = rise[12];
  wire rel_cam_p = rise[13];
  wire start_cam_p = rise[14];
  wire pm_p = rise[15];
  wire fc_cam_p = rise[17];
  wire [10:0] req_p = rise[28:18];
  wire of_p = rise[29];
  wire fcm_lvl = sync2_ff[30];
  wire grp_p = rise[31];
  wire read_p;
  wire head_lvl;

  // Upper inputs are re-indexed to keep the concatenation readable.
  assign read_p = rise[NIN-2];
  assign head_lvl = sync2_ff[NIN-1];

  // Registers and relay state.
  reg [31:0] ctrl_ff;
  reg [31:0] exit_lo_ff;
  reg [31:0] exit_hi_ff;
  reg head_latch_ff;
  reg first_head_ff;
  reg body_start_ff;
  reg head_aux_ff;
  reg [10:0] order_ff;
  reg past_one_ff;
  reg overflow_ff;
  reg in_flight_ff;
  reg [5:0] lines_ff;
  reg [10:0] rel_latch_ff;

  wire suppress = ctrl_ff[`CTRL_SUPPRESS];
  wire fcm_wired = ctrl_ff[`CTRL_FCM_WIRED];
  wire of_to_one = ctrl_ff[`CTRL_OF_TO_ONE];
  wire [47:0] exit_map = {exit_hi_ff[15:0], exit_lo_ff};
  wire any_other = |order_ff[10:1];

  // Per-channel stop arming, release latches and release paths.
  wire [10:0] armed;
  wire [10:0] rel_path;
  wire [10:0] rel_set;
  wire [10:0] higher;
  genvar g;
  generate
    for (g = 0; g < 11; g = g + 1) begin : chan
      wire [3:0] exit_ch = exit_map[4*g+3:4*g];
      wire exit_hit;
      // Exit codes above 12 name no brush and are treated as unwired.
      assign exit_hit = (exit_ch != 4'h0) && (exit_ch <= 4'hc) &&
                        brush[exit_ch - 4'h1];
      assign rel_set[g] = brk_p & exit_hit; // RULE16 RULE18
      if (g == 10) begin : top
        assign higher[g] = 1'b0;
      end else begin : mid
        assign higher[g] = |order_ff[10:g+1];
      end
      if (g == 0) begin : one
        assign armed[g] = order_ff[0] & ~any_other;
        assign rel_path[g] = rel_latch_ff[0] & order_ff[0] & ~higher[0];
      end else begin : other
        assign armed[g] = order_ff[g] & (~order_ff[0] | past_one_ff); // RULE6
        assign rel_path[g] = rel_latch_ff[g] & order_ff[g] & ~higher[g] &
                             (~order_ff[0] | past_one_ff); // RULE20
      end
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rel_latch_ff[g] <= 1'b0;
        end else if (ce) begin
          if (rel_set[g]) begin
            rel_latch_ff[g] <= 1'b1; // RULE17
          end else if (brk_p && brush[g]) begin
            rel_latch_ff[g] <= 1'b0; // RULE17
          end
        end
      end
    end
  endgenerate

  wire stop_hit = brk_p & |(armed & brush[10:0]); // RULE9
  wire any_order = |order_ff;
  wire any_release = |rel_path & ~(overflow_ff & of_to_one); // RULE14

  // Order set terms.
  wire set_one_fcm = fcm_wired & fc_cam_p & fcm_lvl; // RULE4 RULE10
  wire set_two_auto = pm_p & body_start_ff & ~first_head_ff; // RULE2
  wire block_two = first_head_ff & ~body_start_ff; // RULE2
  wire set_two_comb = pm_p & ~first_head_ff & ~body_start_ff &
                      order_ff[0]; // RULE7
  wire set_of = pm_p & overflow_ff;
  wire [10:0] nxt_order_set = (req_p & ~{9'h000, block_two, 1'b0}) |
                              {9'h000, set_two_auto | set_two_comb | set_of,
                               set_one_fcm | set_of};

  // Heading control and skip sequencing.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_latch_ff <= 1'b0;
      first_head_ff <= 1'b0;
      heading_card_relay <= 1'b0;
      body_start_ff <= 1'b0;
      head_aux_ff <= 1'b0;
      total_program_start <= 1'b0;
      order_ff <= 11'h000;
      past_one_ff <= 1'b0;
      overflow_ff <= 1'b0;
      skip_run_relay <= 1'b0;
      carriage_skip_start <= 1'b0;
      high_speed_stop_relay <= 1'b0;
      interlock_release_relay <= 1'b0;
      card_feed_clutch_control <= 1'b1;
      in_flight_ff <= 1'b0;
      lines_ff <= 6'd0;
    end else if (ce) begin
      total_program_start <= 1'b0;
      if (read_p) begin
        if (head_lvl) begin
          head_latch_ff <= 1'b1; // RULE1
          first_head_ff <= 1'b1; // RULE1
          heading_card_relay <= 1'b1; // RULE1
          body_start_ff <= 1'b0;
        end else begin
          head_latch_ff <= 1'b0;
          heading_card_relay <= 1'b0;
          head_aux_ff <= 1'b0;
          if (first_head_ff) begin
            first_head_ff <= 1'b0;
            body_start_ff <= 1'b1;
          end
        end
      end
      if (grp_p) begin
        if (heading_card_relay) begin
          head_aux_ff <= 1'b1;
        end else if (!(read_p && head_lvl)) begin
          total_program_start <= 1'b1; // RULE3
        end
      end
      if (stop_hit) begin
        // A request arriving with the stop is kept for the next skip.
        order_ff <= nxt_order_set; // RULE21
        past_one_ff <= 1'b0; // RULE21
        overflow_ff <= 1'b0;
        skip_run_relay <= 1'b0;
        carriage_skip_start <= 1'b0;
        interlock_release_relay <= 1'b0;
        high_speed_stop_relay <= 1'b1; // RULE9
        body_start_ff <= body_start_ff & ~order_ff[1];
      end else begin
        order_ff <= order_ff | nxt_order_set;
        if (brk_p && brush[0] && order_ff[0] && any_other) begin
          past_one_ff <= 1'b1; // RULE8
        end
        if (any_order) begin
          skip_run_relay <= 1'b1; // RULE5
        end
        if (skip_run_relay && start_cam_p) begin
          carriage_skip_start <= 1'b1; // RULE5 RULE12
          high_speed_stop_relay <= 1'b0;
          lines_ff <= 6'd0;
        end else if (carriage_skip_start && brk_p &&
                     lines_ff != 6'h3f) begin
          lines_ff <= lines_ff + 6'd1;
        end
        if (rel_cam_p && any_release && skip_run_relay) begin
          interlock_release_relay <= 1'b1; // RULE19
        end
      end
      if (of_p && !head_lvl && !order_ff[0]) begin
        overflow_ff <= 1'b1;
      end
      // Clutch is latched out during a skip unless a bypass holds.
      card_feed_clutch_control <= ~skip_run_relay | interlock_release_relay |
                                  (suppress & ~overflow_ff &
                                   ~(of_to_one & order_ff[0])); // RULE11 RULE13 RULE14 RULE19
      if (suppress && carriage_skip_start && !overflow_ff &&
          lines_ff > `LINES_PER_PRINT_CYCLE) begin
        in_flight_ff <= 1'b1; // RULE12 RULE15
      end
    end
  end

  // Status and orders read views.
  wire [31:0] status_word = {10'h000, lines_ff, 3'h0, in_flight_ff,
                             head_aux_ff, overflow_ff,
                             card_feed_clutch_control, high_speed_stop_relay,
                             interlock_release_relay, past_one_ff,
                             carriage_skip_start, skip_run_relay,
                             body_start_ff, heading_card_relay,
                             first_head_ff, head_latch_ff};
  wire [31:0] orders_word = {5'h00, rel_latch_ff, 5'h00, order_ff};
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire aligned = (paddr[1:0] == 2'b00);
  reg [31:0] nxt_prdata;
  reg nxt_err;

  always @* begin
    nxt_prdata = 32'h0000_0000;
    nxt_err = 1'b0;
    case (paddr)
      `OFS_CTRL: nxt_prdata = {29'h0000_0000, ctrl_ff[2:0]};
      `OFS_EXIT_LO: nxt_prdata = exit_lo_ff;
      `OFS_EXIT_HI: nxt_prdata = {20'h00000, exit_hi_ff[11:0]};
      `OFS_STATUS: nxt_prdata = status_word;
      `OFS_ORDERS: nxt_prdata = orders_word;
      default: nxt_err = 1'b1;
    endcase
    if (pwrite && (paddr == `OFS_STATUS || paddr == `OFS_ORDERS)) begin
      nxt_err = 1'b1;
    end
    if (!aligned) begin
      nxt_err = 1'b1;
    end
  end

  // APB slave: answers in the first access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `CTRL_RESET;
      exit_lo_ff <= `EXIT_RESET;
      exit_hi_ff <= `EXIT_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : nxt_prdata;
        pslverr <= nxt_err;
      end else begin
        pslverr <= 1'b0;
      end
      if (access && pready && pwrite && !pslverr) begin
        case (paddr)
          `OFS_CTRL: ctrl_ff <= {29'h0000_0000, pwdata[2:0]};
          `OFS_EXIT_LO: exit_lo_ff <= pwdata;
          `OFS_EXIT_HI: exit_hi_ff <= {20'h00000, pwdata[11:0]};
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end

endmodule // carriage_skip_interlock_control

`default_nettype wire

/* src/unused_placeholder_none.v */
`default_nettype none
`default_nettype wire

/* dv/carriage_skip_checker_assertions.sv */
/* Port checker for the carriage skip and interlock block.
   Assumes the design runs from pclk with presetn as its reset. */
`default_nettype none
module carriage_skip_checker (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Enable and APB.
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Machine timing.
  input wire logic skip_start_cam,
  input wire logic release_pick_cam,
  input wire logic carriage_breaker,
  // Relay drives.
  input wire logic skip_run_relay,
  input wire logic carriage_skip_start,
  input wire logic high_speed_stop_relay,
  input wire logic card_feed_clutch_control,
  input wire logic interlock_release_relay,
  input wire logic total_program_start,
  input wire logic heading_card_relay
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  a_apb_answer: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood too long");
  a_total_held: assert property (
    heading_card_relay |-> !total_program_start)
    else $error("total started under heading");
  a_start_run: assert property (
    carriage_skip_start |-> skip_run_relay)
    else $error("start without run");
  a_start_cam: assert property (
    $rose(carriage_skip_start) |-> $past(skip_start_cam, 2))
    else $error("start not at cam");
  a_stop_breaker: assert property ($rose(high_speed_stop_relay) |->
    $past(carriage_breaker, 2) && !skip_run_relay)
    else $error("stop not at breaker");
  a_run_held: assert property (
    $fell(skip_run_relay) |-> high_speed_stop_relay)
    else $error("run dropped before stop");
  a_clutch_skip: assert property (
    $fell(card_feed_clutch_control) |-> $past(skip_run_relay))
    else $error("clutch latched outside skip");
  a_release_cam: assert property ($rose(interlock_release_relay) |->
    $past(release_pick_cam, 2) && skip_run_relay)
    else $error("release not at cam");
endmodule // carriage_skip_checker

bind carriage_skip_interlock_control carriage_skip_checker
  i_carriage_skip_checker (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pready(pready),
  .skip_start_cam(skip_start_cam), .release_pick_cam(release_pick_cam),
  .carriage_breaker(carriage_breaker), .skip_run_relay(skip_run_relay),
  .carriage_skip_start(carriage_skip_start),
  .high_speed_stop_relay(high_speed_stop_relay),
  .card_feed_clutch_control(card_feed_clutch_control),
  .interlock_release_relay(interlock_release_relay),
  .total_program_start(total_program_start),
  .heading_card_relay(heading_card_relay));
`default_nettype wire

/* dv/carriage_tape_model.sv */
/* Carriage tape model: advances one line each 16 clocks while a skip
   runs and pulses the breaker with the brushes valid on that line.
   Assumes the block drops its start or raises stop to halt it. */
`default_nettype none
module carriage_tape_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Carriage drive.
  input wire logic skip_start,
  input wire logic stop,
  // Tape side.
  output logic breaker,
  output logic [11:0] brush,
  output int pos
);
  timeunit 1ns;
  timeprecision 1ps;
  int tick;
  // Holes: channel 1 at line 2, channel 2 at line 5, channel 5 at 9.
  function automatic logic [11:0] hole(input int p);
    case (p)
      2: hole = 12'h001;
      5: hole = 12'h002;
      9: hole = 12'h010;
      default: hole = 12'h000;
    endcase
  endfunction
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 0;
      tick <= 0;
      breaker <= 1'b0;
      brush <= 12'hfff;
    end else if (skip_start && !stop) begin
      tick <= (tick + 1) % 16;
      if (tick == 0) pos <= (pos + 1) % 12;
      breaker <= (tick >= 1 && tick <= 3);
      brush <= (tick >= 1 && tick <= 3) ? hole(pos) : ~hole(pos);
    end else begin
      breaker <= 1'b0;
      brush <= ~brush;
    end
  end
endmodule // carriage_tape_model
`default_nettype wire

/* dv/carriage_skip_interlock_control_bench.sv */
/* Self-checking bench for the carriage skip and interlock block.
   Assumes the tape model stands on the carriage side. */
`include "carriage_skip_interlock_consts.vh"
`default_nettype none
module carriage_skip_interlock_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } row_t;
  row_t rows [11] = '{'{12'h000, 1'b0, 32'h0, 32'h2, 1'b0},
    '{12'h008, 1'b1, 32'hffff_f000, 32'h0, 1'b0},
    '{12'h008, 1'b0, 32'h0, 32'h0, 1'b0},
    '{12'h000, 1'b1, 32'hffff_fffa, 32'h0, 1'b0},
    '{12'h000, 1'b0, 32'h0, 32'h2, 1'b0},
    '{12'h004, 1'b1, 32'h0002_0000, 32'h0, 1'b0},
    '{12'h004, 1'b0, 32'h0, 32'h0002_0000, 1'b0},
    '{12'h00c, 1'b1, 32'hffff_ffff, 32'h0, 1'b1},
    '{12'h010, 1'b0, 32'h0, 32'h0, 1'b0},
    '{12'h020, 1'b0, 32'h0, 32'h0, 1'b1},
    '{12'h006, 1'b0, 32'h0, 32'h0, 1'b1}};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, hm = 1'b0, fcm = 1'b0, err, pready, pslverr;
  logic [11:0] paddr = 12'h000, tape_brush;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [7:0] pin = 8'h00;
  logic [10:0] sreq = 11'h000;
  logic run, start, stop, clutch, rel, tps, hcard, brk;
  int pos, fails = 0, tests_run = 0, tp_cnt = 0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (tps === 1'b1) tp_cnt <= tp_cnt + 1;
  carriage_skip_interlock_control i_carriage_skip_interlock_control (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .heading_mark(hm), .card_read(pin[0]), .group_change(pin[1]),
    .first_card_minor(fcm), .overflow_output(pin[6]),
    .skip_request(sreq), .early_first_card_cam(pin[2]),
    .early_all_cycle_impulse(pin[7]), .skip_two_program_pulse(pin[3]),
    .skip_start_cam(pin[4]), .release_pick_cam(pin[5]),
    .carriage_breaker(brk), .tape_brush(tape_brush),
    .skip_run_relay(run), .carriage_skip_start(start),
    .high_speed_stop_relay(stop), .card_feed_clutch_control(clutch),
    .interlock_release_relay(rel), .total_program_start(tps),
    .heading_card_relay(hcard));
  carriage_tape_model i_carriage_tape_model (.pclk(pclk),
    .presetn(presetn), .skip_start(start), .stop(stop), .breaker(brk),
    .brush(tape_brush), .pos(pos));
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      close_out;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task reg_chk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(n, e, rd);
  endtask
  task pulse(input int i);
    pin[i] <= 1'b1;
    repeat (6) @(posedge pclk);
    pin[i] <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task wait_pos(input int p);
    int n;
    n = 0;
    while (pos < p && stop !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) begin
      fails++;
      close_out;
    end
  endtask
  task wait_stop;
    wait_pos(99);
    repeat (4) @(posedge pclk);
    chk("stop", 1, stop);
  endtask
  task do_reset;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    fails++;
    close_out;
  end
  initial begin
    do_reset;
    chk("clutch", 1, clutch);
    chk("run", 0, run);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      chk("pslverr", rows[i].e, err);
      if (!rows[i].w && !rows[i].e) chk("prdata", rows[i].q, rd);
    end
    $display("test registers done");
    // No heading cards: combined skip passes channel 1 and stops at channel 2.
    fcm <= 1'b1;
    pulse(1);
    chk("total start", 1, tp_cnt);
    pulse(2);
    pulse(3);
    reg_chk("orders", `OFS_ORDERS, 32'h3);
    chk("run", 1, run);
    pulse(4);
    chk("start", 1, start);
    chk("clutch", 0, clutch);
    wait_pos(3);
    apb(`OFS_STATUS, 1'b0, 32'h0);
    chk("past one", 1, rd[`ST_PAST_ONE]);
    wait_stop;
    chk("stop line", 5, pos);
    reg_chk("orders", `OFS_ORDERS, 32'h0010_0000);
    $display("test combined skip done");
    // Short skip to 5 with its release latch already set.
    sreq[4] <= 1'b1;
    repeat (8) @(posedge pclk);
    pulse(5);
    chk("release", 1, rel);
    chk("clutch", 1, clutch);
    pulse(4);
    sreq[4] <= 1'b0;
    wait_stop;
    chk("stop line", 9, pos);
    reg_chk("orders", `OFS_ORDERS, 32'h0);
    $display("test release done");
    // Suppressed long skip to an unpunched channel, then an overflow.
    apb(`OFS_CTRL, 1'b1, 32'h0000_0003);
    sreq[10] <= 1'b1;
    repeat (8) @(posedge pclk);
    pulse(4);
    chk("clutch", 1, clutch);
    repeat (420) @(posedge pclk);
    apb(`OFS_STATUS, 1'b0, 32'h0);
    chk("in flight", 1, rd[`ST_IN_FLIGHT]);
    pulse(6);
    chk("clutch", 0, clutch);
    sreq[10] <= 1'b0;
    $display("test suppression done");
    // Heading card read after a mid-run reset.
    do_reset;
    hm <= 1'b1;
    pulse(0);
    chk("heading card", 1, hcard);
    apb(`OFS_STATUS, 1'b0, 32'h0);
    chk("heading relays", 3'b111, rd[2:0]);
    pulse(1);
    chk("total start", 1, tp_cnt);
    pulse(2);
    pulse(3);
    reg_chk("orders", `OFS_ORDERS, 32'h1);
    pulse(4);
    wait_stop;
    chk("stop line", 2, pos);
    $display("test heading done");
    close_out;
  end
endmodule // carriage_skip_interlock_control_bench
`default_nettype wire
